// *** rtl/ssw_regs.svh ***
// ssw_regs.svh: codes, field positions, reset values and timing counts
// assumes: included by bare name wherever a constant is needed
`ifndef SSW_REGS_SVH
`define SSW_REGS_SVH
// slave address byte fields and the register word address
`define SSW_TYPE_ARRAY 4'hA
`define SSW_TYPE_REG 4'hB
`define SSW_TYPE_POS 4
`define SSW_ZERO_HI 3
`define SSW_ZERO_LO 2
`define SSW_MSB_POS 1
`define SSW_RW_POS 0
`define SSW_REG_WORD 8'hFF
// control register unlock and latch clear values
`define SSW_UNLOCK1 8'h02
`define SSW_UNLOCK2 8'h06
`define SSW_WEL_CLEAR 8'h00
// reset values and the byte read back with no target
`define SSW_CTRL_RST 8'h00
`define SSW_FAULT_RST 8'h00
`define SSW_IDLE_BYTE 8'hFF
// bit slots within a byte
`define SSW_BIT_LAST 4'h7
`define SSW_BIT_ACK 4'h8
// timing, figures as printed and derived cycle counts
`define SSW_CLK_MHZ 25
`define SSW_TWC_US 5000
`define SSW_TWC_CYC (`SSW_TWC_US * `SSW_CLK_MHZ)
`define SSW_PURST_US 50000
`define SSW_PURST_CYC (`SSW_PURST_US * `SSW_CLK_MHZ)
`define SSW_SCL_NS 2500
`define SSW_QTR_CYC ((`SSW_SCL_NS * `SSW_CLK_MHZ + 3999) / 4000)
// host registers on wishbone
`define SSW_WB_CMD 4'h0
`define SSW_WB_TX 4'h4
`define SSW_WB_RX 4'h8
`define SSW_WB_STAT 4'hC
`define SSW_CMD_START 0
`define SSW_CMD_WRITE 1
`define SSW_CMD_READ 2
`define SSW_CMD_STOP 3
`define SSW_CMD_NACK 4
`endif

// *** rtl/ssw_pkg.sv ***
// ssw_pkg: state types of both ends of the two-wire link
// assumes: nothing imported; users write ssw_pkg::name
package ssw_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WORD, ST_WDATA, ST_RDATA, ST_SKIP,
      ST_BUSY} ssw_dev_st_t;
   typedef enum logic [1:0] {TG_ARRAY, TG_CTRL, TG_FAULT, TG_NONE} ssw_tgt_t;
   typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} ssw_mst_st_t;
   typedef struct packed {
      ssw_dev_st_t st;
      ssw_tgt_t tgt;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ob;
      logic rw;
      logic a8;
      logic [8:0] addr;
      logic mack;
      logic data_ok;
      logic write_enable_latch;
      logic [1:0] step;
      logic [7:0] cr;
      logic [7:0] fault_detection_register;
      logic [15:0][7:0] pbuf;
      logic [15:0] vld;
      logic [4:0] idx;
      logic [31:0] wcnt;
      logic [31:0] por;
      logic psc;
      logic psd;
      logic sda_oe_n;
      logic sup_rst;
      logic standby;
      logic busy;
   } ssw_dev_t;
   typedef struct packed {
      ssw_mst_st_t st;
      logic [15:0] div;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [4:0] cmd;
      logic [7:0] tx;
      logic [7:0] rx;
      logic ack;
      logic busy;
      logic scl;
      logic sda_oe_n;
      logic wb_ack;
      logic [31:0] wb_dat;
   } ssw_mst_t;
endpackage

// *** rtl/ssw_if.sv ***
// ssw_if: two-wire link between the host end and the device end
// assumes: sda is open drain with a pull-up; the host makes scl
`timescale 1ns/1ps
`default_nettype none
interface ssw_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic d_sda_o;
   logic d_sda_oe_n;
   logic sda;
   // wired-and of both drivers, high when nobody pulls
   assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
   modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
   modport device (input scl, output d_sda_o, output d_sda_oe_n, input sda);
endinterface
`default_nettype wire

// *** rtl/ssw_sync.sv ***
// ssw_sync: three-stage pin synchroniser; output moves when stages 2 and 3 agree
// assumes: inputs are asynchronous to i_mclk
`timescale 1ns/1ps
`default_nettype none
module ssw_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // pins in, filtered levels out
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } ssw_sync_t;
   ssw_sync_t r, n;

   // per bit: take a change only once the last two stages agree
   always_comb
   begin
      n = r;
      n.s1 = i_d;
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int k = 0; k < W; k++)
      begin
         if (r.s2[k] == r.s3[k])
            n.q[k] = r.s3[k];
      end
   end

   // state register
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      else
         r <= n;
   end

   assign o_q = r.q;
endmodule
`default_nettype wire

// *** rtl/ssw_device.sv ***
// ssw_device: slave end, address select, word address and write guarding
// assumes: the host makes scl and keeps to two-wire framing
//
// The Wishbone register port and the address map were decided locally.
`include "ssw_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ssw_device #(
   parameter int TWC_CYC = `SSW_TWC_CYC,
   parameter int PURST_CYC = `SSW_PURST_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // two-wire link
   ssw_if.device bus,
   // protect pin
   input wire logic i_wp,
   // status and register contents
   output logic o_sup_reset,
   output logic o_standby,
   output logic o_write_busy,
   output logic o_write_enable_latch,
   output logic [7:0] o_control_register,
   output logic [7:0] o_fault_detection_register
);
   ssw_pkg::ssw_dev_t r, n;
   logic [7:0] mem [0:511];
   logic [2:0] pins;
   logic scl;
   logic sda;
   logic wp;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic match;
   logic wr_ok;
   logic [7:0] rbyte;
   logic [3:0] slot;

   // scl, sda and protect pin all come from outside
   ssw_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_d({bus.scl, bus.sda, i_wp}),
      .o_q(pins)
   );

   // bus events and decodes
   always_comb
   begin
      scl = pins[2];
      sda = pins[1];
      wp = pins[0];
      rise = scl & ~r.psc;
      fall = ~scl & r.psc;
      start = scl & r.psc & r.psd & ~sda;
      stop = scl & r.psc & ~r.psd & sda;
      match = ((r.sh[7:`SSW_TYPE_POS] == `SSW_TYPE_ARRAY)
         | (r.sh[7:`SSW_TYPE_POS] == `SSW_TYPE_REG))
         & (r.sh[`SSW_ZERO_HI:`SSW_ZERO_LO] == 2'h0);
      wr_ok = ~wp
         & (r.write_enable_latch | (r.tgt == ssw_pkg::TG_CTRL & r.sh == `SSW_UNLOCK1))
         & (r.tgt != ssw_pkg::TG_NONE);
      slot = (r.tgt == ssw_pkg::TG_ARRAY) ? r.addr[3:0] : 4'h0;
      case (r.tgt)
         ssw_pkg::TG_ARRAY: rbyte = mem[r.addr];
         ssw_pkg::TG_CTRL: rbyte = r.cr;
         ssw_pkg::TG_FAULT: rbyte = r.fault_detection_register;
         default: rbyte = `SSW_IDLE_BYTE;
      endcase
   end

   // next state of the whole slave
   always_comb
   begin
      n = r;
      n.psc = scl;
      n.psd = sda;
      // power-on reset timeout
      if (r.sup_rst)
      begin
         n.por = r.por + 32'h1;
         if (r.por == 32'(PURST_CYC - 1))
            n.sup_rst = 1'b0;
      end
      if (r.st == ssw_pkg::ST_BUSY)
      begin
         // write cycle: bus ignored, buffer drained one slot per cycle
         n.wcnt = r.wcnt + 32'h1;
         if (!r.idx[4])
            n.idx = r.idx + 5'h1;
         if (r.idx == 5'h0 && r.vld[0] && r.tgt == ssw_pkg::TG_FAULT)
            n.fault_detection_register = r.pbuf[0];
         if (r.idx == 5'h0 && r.vld[0] && r.tgt == ssw_pkg::TG_CTRL)
         begin
            if (r.step == 2'h2)
            begin
               n.cr = r.pbuf[0];
               n.step = 2'h0;
            end
            else if (r.pbuf[0] == `SSW_UNLOCK1)
            begin
               n.write_enable_latch = 1'b1;
               n.step = 2'h1;
            end
            else if (r.pbuf[0] == `SSW_UNLOCK2 && r.step == 2'h1)
               n.step = 2'h2;
            else if (r.pbuf[0] == `SSW_WEL_CLEAR)
            begin
               n.write_enable_latch = 1'b0;
               n.step = 2'h0;
            end
            else
               n.step = 2'h0;
         end
         if (r.wcnt == 32'(TWC_CYC - 1))
         begin
            n.st = ssw_pkg::ST_IDLE;
            n.vld = 16'h0;
         end
      end
      else if (start)
      begin
         n.st = ssw_pkg::ST_ADDR;
         // the scl fall that closes the start wraps this to zero
         n.cnt = 4'hF;
         n.sda_oe_n = 1'b1;
         n.vld = 16'h0;
         n.data_ok = 1'b0;
      end
      else if (stop)
      begin
         n.sda_oe_n = 1'b1;
         n.st = ssw_pkg::ST_IDLE;
         if (r.st == ssw_pkg::ST_WDATA && r.cnt == 4'h0 && r.data_ok)
         begin
            n.st = ssw_pkg::ST_BUSY;
            n.idx = 5'h0;
            n.wcnt = 32'h0;
         end
      end
      else if (rise)
      begin
         // data bits shift in, ninth bit is the master's answer
         if (r.cnt < `SSW_BIT_ACK)
            n.sh = {r.sh[6:0], sda};
         else
            n.mack = sda;
      end
      else if (fall && r.st != ssw_pkg::ST_IDLE)
      begin
         n.cnt = r.cnt + 4'h1;
         n.sda_oe_n = 1'b1;
         if (r.cnt == `SSW_BIT_LAST)
         begin
            // entering the ack slot
            case (r.st)
               ssw_pkg::ST_ADDR:
               begin
                  if (match)
                  begin
                     n.sda_oe_n = 1'b0;
                     n.a8 = r.sh[`SSW_MSB_POS];
                     n.rw = r.sh[`SSW_RW_POS];
                     if (r.sh[7:`SSW_TYPE_POS] == `SSW_TYPE_ARRAY)
                        n.tgt = ssw_pkg::TG_ARRAY;
                     else if (r.sh[`SSW_MSB_POS])
                        n.tgt = ssw_pkg::TG_CTRL;
                     else
                        n.tgt = ssw_pkg::TG_FAULT;
                  end
                  else
                     n.st = ssw_pkg::ST_SKIP;
               end
               ssw_pkg::ST_WORD:
               begin
                  n.sda_oe_n = 1'b0;
                  n.addr = {r.a8, r.sh};
                  if (r.tgt != ssw_pkg::TG_ARRAY && r.sh != `SSW_REG_WORD)
                     n.tgt = ssw_pkg::TG_NONE;
               end
               ssw_pkg::ST_WDATA:
               begin
                  if (wr_ok)
                  begin
                     n.sda_oe_n = 1'b0;
                     n.pbuf[slot] = r.sh;
                     n.vld[slot] = 1'b1;
                     n.data_ok = 1'b1;
                     n.addr[3:0] = r.addr[3:0] + 4'h1;
                  end
               end
               default:
               begin
               end
            endcase
         end
         else if (r.cnt == `SSW_BIT_ACK)
         begin
            // leaving the ack slot
            n.cnt = 4'h0;
            case (r.st)
               ssw_pkg::ST_ADDR:
               begin
                  if (r.rw)
                  begin
                     n.st = ssw_pkg::ST_RDATA;
                     n.ob = rbyte;
                     n.sda_oe_n = rbyte[7];
                     n.addr = r.addr + 9'h1;
                  end
                  else
                     n.st = ssw_pkg::ST_WORD;
               end
               ssw_pkg::ST_WORD: n.st = ssw_pkg::ST_WDATA;
               ssw_pkg::ST_SKIP: n.st = ssw_pkg::ST_IDLE;
               ssw_pkg::ST_RDATA:
               begin
                  if (!r.mack)
                  begin
                     n.ob = rbyte;
                     n.sda_oe_n = rbyte[7];
                     n.addr = r.addr + 9'h1;
                  end
                  else
                     n.st = ssw_pkg::ST_IDLE;
               end
               default:
               begin
               end
            endcase
         end
         else if (r.st == ssw_pkg::ST_RDATA)
         begin
            n.ob = {r.ob[6:0], 1'b1};
            n.sda_oe_n = r.ob[6];
         end
      end
      n.standby = (n.st == ssw_pkg::ST_IDLE);
      n.busy = (n.st == ssw_pkg::ST_BUSY);
   end

   // state register with power-up values
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         r <= '0;
         r.st <= ssw_pkg::ST_IDLE;
         r.standby <= 1'b1;
         r.sda_oe_n <= 1'b1;
         r.write_enable_latch <= 1'b0;
         r.sup_rst <= 1'b1;
         r.psc <= 1'b1;
         r.psd <= 1'b1;
         r.cr <= `SSW_CTRL_RST;
         r.fault_detection_register <= `SSW_FAULT_RST;
      end
      else
         r <= n;
   end

   // array commit during the write cycle
   always_ff @(posedge i_mclk)
   begin
      if (r.st == ssw_pkg::ST_BUSY && r.tgt == ssw_pkg::TG_ARRAY && !r.idx[4]
         && r.vld[r.idx[3:0]])
         mem[{r.addr[8:4], r.idx[3:0]}] <= r.pbuf[r.idx[3:0]];
   end

   // outputs straight from flops, sda drive level tied low
   assign bus.d_sda_o = 1'b0;
   assign bus.d_sda_oe_n = r.sda_oe_n;
   assign o_sup_reset = r.sup_rst;
   assign o_standby = r.standby;
   assign o_write_busy = r.busy;
   assign o_write_enable_latch = r.write_enable_latch;
   assign o_control_register = r.cr;
   assign o_fault_detection_register = r.fault_detection_register;
endmodule
`default_nettype wire

// *** rtl/ssw_master.sv ***
// ssw_master: host end, byte engine ordered over classic wishbone
// assumes: software loads address bytes and follows unlock steps
`include "ssw_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ssw_master #(
   parameter int QTR_CYC = `SSW_QTR_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // two-wire link
   ssw_if.master bus
);
   ssw_pkg::ssw_mst_t r, n;
   logic sda;
   logic tick;
   logic req;

   // sda comes back from the wire
   ssw_sync #(.W(1), .RST_VAL(1'h1)) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_d(bus.sda),
      .o_q(sda)
   );

   // register access and bit sequencing
   always_comb
   begin
      n = r;
      req = i_wb_cyc & i_wb_stb & ~r.wb_ack;
      tick = r.busy & (r.div == 16'(QTR_CYC - 1));
      n.wb_ack = req;
      n.wb_dat = 32'h0;
      if (req && !i_wb_we)
      begin
         case (i_wb_adr)
            `SSW_WB_TX: n.wb_dat = {24'h0, r.tx};
            `SSW_WB_RX: n.wb_dat = {24'h0, r.rx};
            `SSW_WB_STAT: n.wb_dat = {30'h0, r.ack, r.busy};
            default: n.wb_dat = 32'h0;
         endcase
      end
      if (req && i_wb_we && i_wb_sel[0] && i_wb_adr == `SSW_WB_TX)
         n.tx = i_wb_dat[7:0];
      if (req && i_wb_we && i_wb_sel[0] && i_wb_adr == `SSW_WB_CMD && !r.busy)
      begin
         n.cmd = i_wb_dat[4:0];
         n.busy = 1'b1;
         n.div = 16'h0;
         n.ph = 2'h0;
         n.bitn = 4'h0;
         if (i_wb_dat[`SSW_CMD_START])
            n.st = ssw_pkg::MS_START;
         else if (i_wb_dat[`SSW_CMD_WRITE] | i_wb_dat[`SSW_CMD_READ])
            n.st = ssw_pkg::MS_BIT;
         else if (i_wb_dat[`SSW_CMD_STOP])
            n.st = ssw_pkg::MS_STOP;
         else
            n.busy = 1'b0;
      end
      if (r.busy)
         n.div = tick ? 16'h0 : r.div + 16'h1;
      if (tick)
      begin
         n.ph = r.ph + 2'h1;
         case (r.st)
            ssw_pkg::MS_START:
            begin
               case (r.ph)
                  2'h0: n.sda_oe_n = 1'b1;
                  2'h1: n.scl = 1'b1;
                  2'h2: n.sda_oe_n = 1'b0;
                  default:
                  begin
                     n.scl = 1'b0;
                     if (r.cmd[`SSW_CMD_WRITE] | r.cmd[`SSW_CMD_READ])
                        n.st = ssw_pkg::MS_BIT;
                     else if (r.cmd[`SSW_CMD_STOP])
                        n.st = ssw_pkg::MS_STOP;
                     else
                     begin
                        n.st = ssw_pkg::MS_IDLE;
                        n.busy = 1'b0;
                     end
                  end
               endcase
            end
            ssw_pkg::MS_BIT:
            begin
               case (r.ph)
                  2'h0:
                  begin
                     if (r.cmd[`SSW_CMD_WRITE])
                        n.sda_oe_n = r.bitn[3] | r.tx[~r.bitn[2:0]];
                     else
                        n.sda_oe_n = ~r.bitn[3] | r.cmd[`SSW_CMD_NACK];
                  end
                  2'h1: n.scl = 1'b1;
                  2'h2:
                  begin
                     if (r.cmd[`SSW_CMD_WRITE] && r.bitn[3])
                        n.ack = ~sda;
                     if (!r.cmd[`SSW_CMD_WRITE] && !r.bitn[3])
                        n.rx = {r.rx[6:0], sda};
                  end
                  default:
                  begin
                     n.scl = 1'b0;
                     n.bitn = r.bitn + 4'h1;
                     if (r.bitn[3])
                     begin
                        n.sda_oe_n = 1'b1;
                        n.st = r.cmd[`SSW_CMD_STOP] ? ssw_pkg::MS_STOP : ssw_pkg::MS_IDLE;
                        n.busy = r.cmd[`SSW_CMD_STOP];
                     end
                  end
               endcase
            end
            ssw_pkg::MS_STOP:
            begin
               // stop after a byte and its ack slot, after a start, or when ordered on its own
               case (r.ph)
                  2'h0: n.sda_oe_n = 1'b0;
                  2'h1: n.scl = 1'b1;
                  2'h2: n.sda_oe_n = 1'b1;
                  default:
                  begin
                     n.st = ssw_pkg::MS_IDLE;
                     n.busy = 1'b0;
                  end
               endcase
            end
            default: n.busy = 1'b0;
         endcase
      end
   end

   // state register
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         r <= '0;
         r.st <= ssw_pkg::MS_IDLE;
         r.scl <= 1'b1;
         r.sda_oe_n <= 1'b1;
      end
      else
         r <= n;
   end

   // outputs straight from flops, sda drive level tied low
   assign o_wb_ack = r.wb_ack;
   assign o_wb_dat = r.wb_dat;
   assign bus.scl = r.scl;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe_n = r.sda_oe_n;
endmodule
`default_nettype wire

// *** verification/ssw_props.sv ***
// ssw_props: timing relations on the two-wire link and device status
// assumes: placed in tb_top beside ssw_if; one clock domain
`timescale 1ns/1ps
`default_nettype none
module ssw_props #(
   parameter int TWC_CYC = 50,
   parameter int PURST_CYC = 20
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // link and device status
   input wire logic scl,
   input wire logic sda,
   input wire logic d_sda_oe_n,
   input wire logic i_wp,
   input wire logic o_sup_reset,
   input wire logic o_standby,
   input wire logic o_write_busy,
   input wire logic o_write_enable_latch,
   input wire logic [7:0] o_control_register
);
   logic [15:0] rcnt;
   logic [15:0] bcnt;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   // cycles since reset release and length of the write cycle
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rcnt <= 16'h0000;
         bcnt <= 16'h0000;
      end
      else
      begin
         rcnt <= rcnt + 16'h0001;
         bcnt <= o_write_busy ? bcnt + 16'h0001 : 16'h0000;
      end
   end
   sequence s_start;
      scl && $fell(sda);
   endsequence
   sequence s_bus_free;
      scl && sda;
   endsequence
   a_reset_state: assert property ($fell(i_rst) |-> o_standby && d_sda_oe_n &&
      !o_write_enable_latch && o_control_register == 8'h00) else $error("bad state after reset");
   a_por_length: assert property ($fell(o_sup_reset) |->
      rcnt >= PURST_CYC - 2 && rcnt <= PURST_CYC + 2) else $error("power-on hold length wrong");
   a_busy_length: assert property ($fell(o_write_busy) |->
      bcnt >= TWC_CYC - 2 && bcnt <= TWC_CYC + 2) else $error("write cycle length wrong");
   a_commit_on_stop: assert property ($rose(o_write_busy) |-> s_bus_free)
      else $error("write cycle began without a stop");
   a_busy_silent: assert property (o_write_busy |-> d_sda_oe_n)
      else $error("device drives data during write cycle");
   a_standby_silent: assert property (o_standby |-> d_sda_oe_n)
      else $error("device drives data in standby");
   a_pull_scl_low: assert property ($fell(d_sda_oe_n) |-> !scl)
      else $error("device pulled data while clock high");
   a_start_wakes: assert property (!o_write_busy ##0 s_start |-> ##[1:10] !o_standby)
      else $error("start did not leave standby");
   a_protect_blocks: assert property ($rose(o_write_busy) |-> !$past(i_wp, 8))
      else $error("write cycle while protect high");
   a_ctrl_in_cycle: assert property ($changed(o_control_register) |->
      o_write_busy || $past(o_write_busy)) else $error("control changed outside a write");
   a_latch_in_cycle: assert property ($changed(o_write_enable_latch) |->
      o_write_busy || $past(o_write_busy)) else $error("latch changed outside a write");
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// tb_top: both link ends joined, host end ordered over wishbone
// assumes: short write-cycle and power-on counts set at the instances
`include "ssw_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [4:0] c_sw = 5'h03;
   localparam logic [4:0] c_w = 5'h02;
   localparam logic [4:0] c_wp = 5'h0A;
   localparam logic [4:0] c_p = 5'h08;
   localparam logic [4:0] c_rnp = 5'h1C;
   logic i_mclk = 1'h0;
   logic i_rst = 1'h1;
   logic wp = 1'h0;
   logic wb_cyc = 1'h0;
   logic wb_stb = 1'h0;
   logic wb_we = 1'h0;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_dat = 32'h00000000;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic sup_reset;
   logic standby;
   logic busy;
   logic write_enable_latch;
   logic [7:0] ctrl;
   logic [7:0] fault;
   int bad_count = 0;
   int total_checks = 0;
   logic [7:0] sel_tab [7] = '{8'hA0, 8'hB2, 8'hB0, 8'h90, 8'hA4, 8'hA8, 8'hE0};
   logic sel_ack [7] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
   // clock
   always #20 i_mclk = ~i_mclk;
   ssw_if ssw_if_i ();
   ssw_master ssw_master_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(wb_cyc),
      .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF),
      .i_wb_dat(wb_dat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .bus(ssw_if_i.master));
   ssw_device #(.TWC_CYC(50), .PURST_CYC(20)) ssw_device_i (.i_mclk(i_mclk), .i_rst(i_rst),
      .bus(ssw_if_i.device), .i_wp(wp), .o_sup_reset(sup_reset), .o_standby(standby),
      .o_write_busy(busy), .o_write_enable_latch(write_enable_latch), .o_control_register(ctrl),
      .o_fault_detection_register(fault));
   ssw_props #(.TWC_CYC(50), .PURST_CYC(20)) ssw_props_i (.i_mclk(i_mclk), .i_rst(i_rst),
      .scl(ssw_if_i.scl), .sda(ssw_if_i.sda), .d_sda_oe_n(ssw_if_i.d_sda_oe_n), .i_wp(wp),
      .o_sup_reset(sup_reset), .o_standby(standby), .o_write_busy(busy),
      .o_write_enable_latch(write_enable_latch), .o_control_register(ctrl));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one classic wishbone cycle, held until ack
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge i_mclk);
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= d;
      @(posedge i_mclk);
      while (wb_ack !== 1'h1)
         @(posedge i_mclk);
      q = wb_rdat;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
      wb_we <= 1'h0;
   endtask
   // one byte command: load, order, poll until done, fetch ack and data
   task automatic op(input logic [4:0] c, input logic [7:0] b, output logic ak,
      output logic [7:0] rd);
      logic [31:0] q;
      wb_xfer(1'h1, `SSW_WB_TX, {24'h000000, b}, q);
      wb_xfer(1'h1, `SSW_WB_CMD, {27'h0000000, c}, q);
      q = 32'h00000001;
      while (q[0] === 1'h1)
         wb_xfer(1'h0, `SSW_WB_STAT, 32'h00000000, q);
      ak = q[1];
      wb_xfer(1'h0, `SSW_WB_RX, 32'h00000000, q);
      rd = q[7:0];
   endtask
   // wait for the write cycle to start and end
   task automatic settle();
      int n;
      n = 0;
      repeat (12) @(posedge i_mclk);
      while (busy === 1'h1 && n < 200)
      begin
         n++;
         @(posedge i_mclk);
      end
   endtask
   task automatic put(input logic [7:0] sa, input logic [7:0] wa, input logic [7:0] d,
      output logic [2:0] ak);
      logic [7:0] rd;
      op(c_sw, sa, ak[2], rd);
      op(c_w, wa, ak[1], rd);
      op(c_wp, d, ak[0], rd);
      settle();
   endtask
   task automatic get(input logic [7:0] sa, input logic [7:0] wa, output logic [7:0] d);
      logic ak;
      op(c_sw, sa, ak, d);
      op(c_w, wa, ak, d);
      op(c_sw, sa | 8'h01, ak, d);
      op(c_rnp, 8'h00, ak, d);
   endtask
   // main sequence
   initial
   begin
      logic [2:0] ak;
      logic [7:0] d;
      logic a;
      repeat (6) @(posedge i_mclk);
      i_rst <= 1'h0;
      @(posedge i_mclk);
      chk("sup_reset", sup_reset, 1'h1);
      chk("standby", standby, 1'h1);
      chk("latch", write_enable_latch, 1'h0);
      repeat (40) @(posedge i_mclk);
      chk("sup_reset end", sup_reset, 1'h0);
      foreach (sel_tab[k])
      begin
         op(c_sw, sel_tab[k], a, d);
         chk("select ack", a, sel_ack[k]);
         op(c_p, 8'h00, a, d);
         repeat (12) @(posedge i_mclk);
         chk("no commit", busy, 1'h0);
         chk("back to standby", standby, 1'h1);
      end
      put(8'hA2, 8'h10, 8'h55, ak);
      chk("latch clear ack", ak, 3'h6);
      put(8'hB2, 8'hFF, 8'h02, ak);
      chk("set latch ack", ak, 3'h7);
      chk("latch set", write_enable_latch, 1'h1);
      op(c_sw, 8'hA2, a, d);
      op(c_w, 8'h10, a, d);
      op(c_w, 8'h55, a, d);
      op(c_wp, 8'h66, a, d);
      chk("page ack", a, 1'h1);
      settle();
      put(8'hA0, 8'h10, 8'h77, ak);
      get(8'hA2, 8'h10, d);
      chk("read 110", d, 8'h55);
      op(c_sw, 8'hA3, a, d);
      op(c_rnp, 8'h00, a, d);
      chk("current read", d, 8'h66);
      get(8'hA0, 8'h10, d);
      chk("read 010", d, 8'h77);
      wp <= 1'h1;
      put(8'hA2, 8'h10, 8'h99, ak);
      chk("protect array", ak, 3'h6);
      put(8'hB2, 8'hFF, 8'h00, ak);
      chk("protect reg", ak, 3'h6);
      chk("latch kept", write_enable_latch, 1'h1);
      wp <= 1'h0;
      get(8'hA2, 8'h10, d);
      chk("array kept", d, 8'h55);
      put(8'hB0, 8'hFF, 8'h5A, ak);
      chk("fault reg", fault, 8'h5A);
      put(8'hB0, 8'h10, 8'h11, ak);
      chk("reg word", ak, 3'h6);
      put(8'hB2, 8'hFF, 8'h0C, ak);
      chk("no unlock", ctrl, 8'h00);
      put(8'hB2, 8'hFF, 8'h02, ak);
      put(8'hB2, 8'hFF, 8'h06, ak);
      put(8'hB2, 8'hFF, 8'h0C, ak);
      chk("unlocked", ctrl, 8'h0C);
      put(8'hB2, 8'hFF, 8'h00, ak);
      chk("latch cleared", write_enable_latch, 1'h0);
      put(8'hA2, 8'h20, 8'h44, ak);
      chk("refused again", ak, 3'h6);
      wrap_up();
   end
   // hang guard
   initial
   begin
      repeat (95000) @(posedge i_mclk);
      bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
